// File: hw/eel_pkg.sv
// constants shared by the edge event logger design files
package eel_pkg;

	// ----------------------------------------------------------------
	// clock and time base
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	// debounce base step (plain default; duration code n waits 2^n of these steps)
	localparam int DB_STEP_NS    = 100000;
	localparam int DB_STEP_CYC   = (DB_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DB_DIV_W      = 10;
	// cycles until the sync and filter stages show live source levels
	localparam logic [1:0] WARM_DONE = 2'h3;

	// ----------------------------------------------------------------
	// sizes and field widths
	// ----------------------------------------------------------------
	localparam int NUM_CH    = 16;
	localparam int DEPTH     = 16;
	localparam int PTR_W     = 4;
	localparam int SRC_W     = 5;
	localparam int NUM_SRC   = 32;
	localparam int TS_W      = 32;
	localparam int DB_CODE_W = 4;
	localparam int DB_CNT_W  = 16;

	// ----------------------------------------------------------------
	// encodings and reset values
	// ----------------------------------------------------------------
	localparam logic             POL_RISING  = 1'b0;
	localparam logic             TIMER_ONE   = 1'b0;
	localparam logic [PTR_W-1:0] PTR_RST     = 4'h0;
	localparam logic [SRC_W-1:0] ID_RST      = 5'h00;
	localparam logic [TS_W-1:0]  TS_RST      = 32'h0000_0000;

endpackage

// File: hw/eel_sync.sv
// two-flop synchroniser for a vector of independent levels
`timescale 1ns/1ns
module eel_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  logic         clk,
	input  logic         rst_n,
	// levels
	input  logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_q;

	// first stage is read only by the second stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule

// File: hw/eel_debounce.sv
// one-channel debounce filter stepped by a shared tick enable
`timescale 1ns/1ns
module eel_debounce
	import eel_pkg::*;
(
	// clock and reset
	input  logic                 clk,
	input  logic                 rst_n,
	// control
	input  logic                 tick,
	input  logic                 enable,
	input  logic [DB_CODE_W-1:0] code,
	// levels
	input  logic                 raw,
	output logic                 filt_q
);

	logic [DB_CNT_W-1:0] cnt_q;
	logic [DB_CNT_W-1:0] limit;

	// stable time is 2^code ticks; the largest code, 15, still fits the 16-bit counter
	assign limit = DB_CNT_W'(1) << code;

	// a bypassed channel follows its source directly
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			filt_q <= 1'b0;
			cnt_q  <= '0;
		end else if (!enable || raw == filt_q) begin
			filt_q <= raw;
			cnt_q  <= '0;
		end else if (tick) begin
			if (cnt_q >= limit - DB_CNT_W'(1)) begin
				filt_q <= raw;
				cnt_q  <= '0;
			end else begin
				cnt_q <= cnt_q + DB_CNT_W'(1);
			end
		end
	end

endmodule

// File: hw/eel_top.sv
// edge event logger: channels, arbiter, cyclic record buffer and status flags
//
// Functional notes
// - events are detected and recorded only while the logger is enabled.
// - a soft reset pulse clears all status flags and the record buffer.
// - sixteen channels, each with source, polarity, debounce enable; shared duration.
// - filtered channel drops an event already present among unread entries.
// - each channel has its own enable while the logger runs.
// - polarity zero means rising edge; one polarity per channel.
// - on logger enable, a source already at its active level logs once.
// - events fill sixteen entries cyclically and never overwrite unread ones.
// - each entry holds source id, polarity and a 32-bit time stamp.
// - write and read indexes; soft reset sets both to zero.
// - unread count is write minus read index modulo sixteen, or sixteen while full.
// - per-channel status shows the level of the selected source.
// - pending flag is set while any unread entry remains.
// - low-space flag rises when free locations reach the threshold.
// - full at sixteen unread; then events are neither logged nor flagged.
// - full clears when the read index is written with a new value, or on soft reset.
// - status flags are outputs for the interrupt controller.
// - one event per cycle, lowest channel first, queued repeats dropped.
// - low-space flag is set while free count is at most the threshold.
`timescale 1ns/1ns
module eel_top
	import eel_pkg::*;
(
	// clock and reset
	input  logic                      CORE_CLK,
	input  logic                      RSTN,
	// logger control
	input  logic                      LOGGER_ENABLE,
	input  logic                      LOGGER_SOFT_RESET,
	input  logic                      STAMP_TIMER_SELECT,
	input  logic [DB_CODE_W-1:0]      DEBOUNCE_DURATION,
	input  logic [PTR_W-1:0]          LOW_SPACE_THRESHOLD,
	// time stamp sources
	input  logic [TS_W-1:0]           TIMER1_VALUE,
	input  logic [TS_W-1:0]           TIMER2_VALUE,
	// monitored signals
	input  logic [NUM_SRC-1:0]        SOURCE_IN,
	// channel configuration
	input  logic [NUM_CH*SRC_W-1:0]   CHANNEL_SOURCE_SELECT,
	input  logic [NUM_CH-1:0]         CHANNEL_EDGE_POLARITY,
	input  logic [NUM_CH-1:0]         CHANNEL_DEBOUNCE_ENABLE,
	input  logic [NUM_CH-1:0]         CHANNEL_DUPLICATE_FILTER,
	input  logic [NUM_CH-1:0]         CHANNEL_ENABLE,
	// read index update
	input  logic                      READ_INDEX_WR,
	input  logic [PTR_W-1:0]          READ_INDEX_WDATA,
	// entry readout
	input  logic [PTR_W-1:0]          ENTRY_INDEX,
	output logic [SRC_W-1:0]          ENTRY_SOURCE_ID,
	output logic                      ENTRY_POLARITY,
	output logic [TS_W-1:0]           ENTRY_TIME_STAMP,
	// status
	output logic [NUM_CH-1:0]         CHANNEL_LEVEL_STATUS,
	output logic [PTR_W-1:0]          RECORD_WRITE_POINTER,
	output logic [PTR_W-1:0]          RECORD_READ_POINTER,
	output logic                      RECORDS_PENDING_FLAG,
	output logic                      LOW_SPACE_FLAG,
	output logic                      RECORDS_FULL_FLAG
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------

	// unread count from the two indexes, wrapping past the top index
	function automatic logic [PTR_W-1:0] fill_of(input logic [PTR_W-1:0] w,
	                                             input logic [PTR_W-1:0] r);
		fill_of = w - r;
	endfunction

	// free locations; equal indexes while full leaves none
	function automatic logic [PTR_W:0] free_of(input logic [PTR_W-1:0] w,
	                                           input logic [PTR_W-1:0] r,
	                                           input logic             f);
		free_of = f ? '0 : (PTR_W+1)'(DEPTH) - {1'b0, fill_of(w, r)};
	endfunction

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [NUM_SRC-1:0]   src_sync;
	logic [NUM_CH-1:0]    raw_lvl;
	logic [NUM_CH-1:0]    db_lvl;
	logic [DB_DIV_W-1:0]  div_q;
	logic                 tick_q;
	logic [1:0]           warm_q;
	logic                 log_on;
	logic [NUM_CH-1:0]    prev_q;
	logic [NUM_CH-1:0]    pend_q;
	logic [NUM_CH-1:0]    edge_hit;
	logic [NUM_CH-1:0]    new_evt;
	logic [NUM_CH-1:0]    grant;
	logic [PTR_W-1:0]     gnt_idx;
	logic [SRC_W-1:0]     gnt_src;
	logic                 gnt_pol;
	logic                 take;
	logic                 dup_hit;
	logic                 wr_en;
	logic                 drop_dup;
	logic [TS_W-1:0]      stamp;
	logic [PTR_W-1:0]     write_index_q;
	logic [PTR_W-1:0]     write_index_d;
	logic [PTR_W-1:0]     read_index_q;
	logic [PTR_W-1:0]     read_index_d;
	logic                 read_index_moved;
	logic                 full_q;
	logic                 full_d;
	logic [PTR_W:0]       free_d;
	logic [SRC_W-1:0]     id_mem  [DEPTH];
	logic                 pol_mem [DEPTH];
	logic [TS_W-1:0]      ts_mem  [DEPTH];

	// ----------------------------------------------------------------
	// source selection and conditioning
	// ----------------------------------------------------------------

	// sources may come from pins or other clocks, so all are synchronised
	eel_sync #(
		.W (NUM_SRC)
	) u_src_sync (
		.clk   (CORE_CLK),
		.rst_n (RSTN),
		.d     (SOURCE_IN),
		.q     (src_sync)
	);

	// per-channel source multiplexer
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			raw_lvl[i] = src_sync[CHANNEL_SOURCE_SELECT[i*SRC_W +: SRC_W]];
		end
	end

	// divider giving the debounce step as a one-cycle enable
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			div_q  <= '0;
			tick_q <= 1'b0;
		end else if (div_q == DB_DIV_W'(DB_STEP_CYC - 1)) begin
			div_q  <= '0;
			tick_q <= 1'b1;
		end else begin
			div_q  <= div_q + DB_DIV_W'(1);
			tick_q <= 1'b0;
		end
	end

	// one debounce filter per channel, all sharing one duration code
	for (genvar g = 0; g < NUM_CH; g++) begin : g_db
		eel_debounce u_db (
			.clk    (CORE_CLK),
			.rst_n  (RSTN),
			.tick   (tick_q),
			.enable (CHANNEL_DEBOUNCE_ENABLE[g]),
			.code   (DEBOUNCE_DURATION),
			.raw    (raw_lvl[g]),
			.filt_q (db_lvl[g])
		);
	end

	// channel status shows the undebounced selected level
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			CHANNEL_LEVEL_STATUS <= '0;
		end else begin
			CHANNEL_LEVEL_STATUS <= raw_lvl;
		end
	end

	// ----------------------------------------------------------------
	// edge detection and queueing
	// ----------------------------------------------------------------

	// sync and filter stages hold reset values for a few cycles; logging
	// waits for live levels, else a falling channel sees a false low
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			warm_q <= '0;
		end else if (warm_q != WARM_DONE) begin
			warm_q <= warm_q + 2'h1;
		end
	end

	assign log_on = LOGGER_ENABLE & (warm_q == WARM_DONE);

	// active level is the inverse of the polarity bit (zero means rising)
	assign edge_hit = (db_lvl ^ CHANNEL_EDGE_POLARITY)
	                & ~(prev_q ^ CHANNEL_EDGE_POLARITY);
	// nothing is queued while full or while the logger is off
	assign new_evt  = edge_hit & CHANNEL_ENABLE
	                & {NUM_CH{log_on & ~full_q}};

	// while disabled the history sits at the inactive level, so a source
	// already active on enable is seen as one edge
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			prev_q <= '0;
		end else if (log_on) begin
			prev_q <= db_lvl;
		end else begin
			prev_q <= CHANNEL_EDGE_POLARITY;
		end
	end

	// one pending bit per channel absorbs repeats of a queued event
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			pend_q <= '0;
		end else if (LOGGER_SOFT_RESET || !log_on) begin
			pend_q <= '0;
		end else begin
			pend_q <= (pend_q & ~grant) | new_evt;
		end
	end

	// ----------------------------------------------------------------
	// arbitration and duplicate filter
	// ----------------------------------------------------------------

	// lowest set bit wins: isolate it with its two's complement
	always_comb begin
		grant   = '0;
		gnt_idx = '0;
		if (take) begin
			grant = pend_q & (~pend_q + NUM_CH'(1));
		end
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (pend_q[i]) begin
				gnt_idx = PTR_W'(i);
			end
		end
	end

	assign take    = (|pend_q) & log_on & ~full_q & ~LOGGER_SOFT_RESET;
	assign gnt_src = CHANNEL_SOURCE_SELECT[gnt_idx*SRC_W +: SRC_W];
	assign gnt_pol = CHANNEL_EDGE_POLARITY[gnt_idx];

	// search the unread span for the same source and polarity
	always_comb begin
		dup_hit = 1'b0;
		for (int e = 0; e < DEPTH; e++) begin
			if ((fill_of(PTR_W'(e), read_index_q) < fill_of(write_index_q, read_index_q))
			    && id_mem[e] == gnt_src && pol_mem[e] == gnt_pol) begin
				dup_hit = 1'b1;
			end
		end
	end

	assign drop_dup = take & dup_hit & CHANNEL_DUPLICATE_FILTER[gnt_idx];
	assign wr_en    = take & ~drop_dup;

	// timer select must only change with the logger off, so no guard here
	assign stamp = (STAMP_TIMER_SELECT == TIMER_ONE) ? TIMER1_VALUE : TIMER2_VALUE;

	// ----------------------------------------------------------------
	// record buffer
	// ----------------------------------------------------------------

	// entry and stamp land on the same edge that moves the write index
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			for (int e = 0; e < DEPTH; e++) begin
				id_mem[e]  <= ID_RST;
				pol_mem[e] <= POL_RISING;
				ts_mem[e]  <= TS_RST;
			end
		end else if (LOGGER_SOFT_RESET) begin
			for (int e = 0; e < DEPTH; e++) begin
				id_mem[e]  <= ID_RST;
				pol_mem[e] <= POL_RISING;
				ts_mem[e]  <= TS_RST;
			end
		end else if (wr_en) begin
			id_mem[write_index_q]  <= gnt_src;
			pol_mem[write_index_q] <= gnt_pol;
			ts_mem[write_index_q]  <= stamp;
		end
	end

	// any index may be read at any time; order is left to software
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			ENTRY_SOURCE_ID  <= ID_RST;
			ENTRY_POLARITY   <= POL_RISING;
			ENTRY_TIME_STAMP <= TS_RST;
		end else begin
			ENTRY_SOURCE_ID  <= id_mem[ENTRY_INDEX];
			ENTRY_POLARITY   <= pol_mem[ENTRY_INDEX];
			ENTRY_TIME_STAMP <= ts_mem[ENTRY_INDEX];
		end
	end

	// ----------------------------------------------------------------
	// indexes and flags
	// ----------------------------------------------------------------

	// next-state values, so every flag output is itself a flop
	always_comb begin
		write_index_d     = write_index_q;
		read_index_d     = read_index_q;
		read_index_moved = 1'b0;
		if (LOGGER_SOFT_RESET) begin
			write_index_d = PTR_RST;
			read_index_d = PTR_RST;
		end else begin
			if (wr_en) begin
				write_index_d = write_index_q + PTR_W'(1);
			end
			if (READ_INDEX_WR) begin
				read_index_d     = READ_INDEX_WDATA;
				read_index_moved = READ_INDEX_WDATA != read_index_q;
			end
		end
		// a same-cycle soft reset clear wins over a write that closes the gap
		if (LOGGER_SOFT_RESET) begin
			full_d = 1'b0;
		end else begin
			full_d = (wr_en && write_index_d == read_index_d)
			       || (full_q && !read_index_moved);
		end
		free_d = free_of(write_index_d, read_index_d, full_d);
	end

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			write_index_q <= PTR_RST;
			read_index_q <= PTR_RST;
			full_q <= 1'b0;
		end else begin
			write_index_q <= write_index_d;
			read_index_q <= read_index_d;
			full_q <= full_d;
		end
	end

	// flags leave the block for the interrupt controller
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			RECORDS_PENDING_FLAG <= 1'b0;
			LOW_SPACE_FLAG       <= 1'b0;
		end else begin
			RECORDS_PENDING_FLAG <= (write_index_d != read_index_d) || full_d;
			LOW_SPACE_FLAG       <= free_d <= {1'b0, LOW_SPACE_THRESHOLD};
		end
	end

	assign RECORD_WRITE_POINTER = write_index_q;
	assign RECORD_READ_POINTER  = read_index_q;
	assign RECORDS_FULL_FLAG    = full_q;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------

	property p_idle_no_write;
		@(posedge CORE_CLK) disable iff (!RSTN)
		!LOGGER_ENABLE && !LOGGER_SOFT_RESET |=> write_index_q == $past(write_index_q);
	endproperty
	a_idle_no_write: assert property (p_idle_no_write)
		else $error("write index moved while logger disabled");

	property p_soft_reset;
		@(posedge CORE_CLK) disable iff (!RSTN)
		LOGGER_SOFT_RESET |=> write_index_q == '0 && read_index_q == '0 && !full_q
		                      && !RECORDS_PENDING_FLAG && ts_mem[0] == '0;
	endproperty
	a_soft_reset: assert property (p_soft_reset)
		else $error("soft reset left state behind");

	property p_cyclic_write;
		@(posedge CORE_CLK) disable iff (!RSTN)
		wr_en |=> write_index_q == PTR_W'($past(write_index_q) + 1)
		          && ts_mem[$past(write_index_q)] == $past(stamp);
	endproperty
	a_cyclic_write: assert property (p_cyclic_write)
		else $error("entry or stamp not stored at write index");

	property p_full_holds;
		@(posedge CORE_CLK) disable iff (!RSTN)
		full_q && !LOGGER_SOFT_RESET |=> write_index_q == $past(write_index_q);
	endproperty
	a_full_holds: assert property (p_full_holds)
		else $error("write while buffer full");

	property p_same_read_index_keeps_full;
		@(posedge CORE_CLK) disable iff (!RSTN)
		full_q && READ_INDEX_WR && READ_INDEX_WDATA == read_index_q
		&& !LOGGER_SOFT_RESET |=> full_q;
	endproperty
	a_same_read_index_keeps_full: assert property (p_same_read_index_keeps_full)
		else $error("rewriting same read index cleared full");

	property p_pending_flag;
		@(posedge CORE_CLK) disable iff (!RSTN)
		RECORDS_PENDING_FLAG == ((write_index_q != read_index_q) || full_q);
	endproperty
	a_pending_flag: assert property (p_pending_flag)
		else $error("pending flag disagrees with indexes");

	property p_low_space;
		@(posedge CORE_CLK) disable iff (!RSTN)
		LOW_SPACE_FLAG == (full_q
		                   || ((PTR_W+1)'(DEPTH) - (PTR_W+1)'(PTR_W'(write_index_q - read_index_q))
		                       <= (PTR_W+1)'($past(LOW_SPACE_THRESHOLD))));
	endproperty
	a_low_space: assert property (p_low_space)
		else $error("low space flag wrong for free count");

	property p_lowest_first;
		@(posedge CORE_CLK) disable iff (!RSTN)
		take |-> $onehot(grant) && (pend_q & (grant - NUM_CH'(1))) == '0;
	endproperty
	a_lowest_first: assert property (p_lowest_first)
		else $error("grant not lowest pending channel");

	property p_dup_drop;
		@(posedge CORE_CLK) disable iff (!RSTN)
		drop_dup && !new_evt[gnt_idx] |=> write_index_q == $past(write_index_q) && !pend_q[$past(gnt_idx)];
	endproperty
	a_dup_drop: assert property (p_dup_drop)
		else $error("filtered duplicate was logged or kept");

	property p_full_at_depth;
		@(posedge CORE_CLK) disable iff (!RSTN)
		wr_en && !READ_INDEX_WR && fill_of(write_index_q, read_index_q) == PTR_W'(DEPTH - 1)
		|=> full_q && RECORDS_PENDING_FLAG;
	endproperty
	a_full_at_depth: assert property (p_full_at_depth)
		else $error("full not raised at sixteen unread");

endmodule

// File: tb/eel_testbench.sv
// self-checking testbench for the edge event logger top
`timescale 1ns/1ns
module testbench;
	import eel_pkg::*;

	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	logic                    core_clk, rst_n, log_en, soft_rst, tsel, rp_wr;
	logic [PTR_W-1:0]        thr, rp_wd, eidx;
	logic [TS_W-1:0]         tim1, tim2;
	logic [NUM_SRC-1:0]      src;
	logic [NUM_CH*SRC_W-1:0] sel;
	logic [NUM_CH-1:0]       pol, filt, ch_en, lvl, db_en;
	logic [DB_CODE_W-1:0]    db_dur;
	logic [SRC_W-1:0]        e_id;
	logic                    e_pol, pend, low, full;
	logic [TS_W-1:0]         e_ts;
	logic [PTR_W-1:0]        wp, rp;
	int                      error_cnt = 0;
	int                      checks = 0;

	// debounce uses the shortest code that still rejects a short glitch
	eel_top uut (
		.CORE_CLK                (core_clk),
		.RSTN                    (rst_n),
		.LOGGER_ENABLE           (log_en),
		.LOGGER_SOFT_RESET       (soft_rst),
		.STAMP_TIMER_SELECT      (tsel),
		.DEBOUNCE_DURATION       (db_dur),
		.LOW_SPACE_THRESHOLD     (thr),
		.TIMER1_VALUE            (tim1),
		.TIMER2_VALUE            (tim2),
		.SOURCE_IN               (src),
		.CHANNEL_SOURCE_SELECT   (sel),
		.CHANNEL_EDGE_POLARITY   (pol),
		.CHANNEL_DEBOUNCE_ENABLE (db_en),
		.CHANNEL_DUPLICATE_FILTER(filt),
		.CHANNEL_ENABLE          (ch_en),
		.READ_INDEX_WR           (rp_wr),
		.READ_INDEX_WDATA        (rp_wd),
		.ENTRY_INDEX             (eidx),
		.ENTRY_SOURCE_ID         (e_id),
		.ENTRY_POLARITY          (e_pol),
		.ENTRY_TIME_STAMP        (e_ts),
		.CHANNEL_LEVEL_STATUS    (lvl),
		.RECORD_WRITE_POINTER    (wp),
		.RECORD_READ_POINTER     (rp),
		.RECORDS_PENDING_FLAG    (pend),
		.LOW_SPACE_FLAG          (low),
		.RECORDS_FULL_FLAG       (full)
	);

	// ----------------------------------------------------------------
	// clock, verdict and shared tasks
	// ----------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;
	end

	task automatic tally_and_finish;
		if (error_cnt == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// inputs always move one ns after the rising edge
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// flags are packed as pending, low space, full
	task automatic state(input logic [3:0] ew, input logic [3:0] er, input logic [2:0] ef);
		chk(32'(wp), 32'(ew), "write index");
		chk(32'(rp), 32'(er), "read index");
		chk(32'({pend, low, full}), 32'(ef), "flags");
	endtask

	task automatic entry(input logic [3:0] i, input logic [4:0] id, input logic p,
	                     input logic [31:0] ts);
		eidx = i;
		cyc(2);
		chk(32'(e_id), 32'(id), "entry id");
		chk(32'(e_pol), 32'(p), "entry polarity");
		chk(e_ts, ts, "entry stamp");
	endtask

	// eight cycles cover the sync flops, edge compare, grant and write
	task automatic set(input int i, input logic v);
		src[i] = v;
		cyc(8);
	endtask

	task automatic pulse(input int i);
		set(i, 1'b1);
		set(i, 1'b0);
	endtask

	task automatic wr_rp(input logic [3:0] v);
		rp_wr = 1'b1;
		rp_wd = v;
		cyc(1);
		rp_wr = 1'b0;
		cyc(1);
	endtask

	// ----------------------------------------------------------------
	// watchdog: the sequence needs well under 5000 cycles
	// ----------------------------------------------------------------
	initial begin
		#(20000 * CLK_PERIOD_NS);
		error_cnt++;
		tally_and_finish();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		log_en = 1'b0;
		soft_rst = 1'b0;
		tsel = TIMER_ONE;
		rp_wr = 1'b0;
		thr = 4'h0;
		rp_wd = 4'h0;
		eidx = 4'h0;
		tim1 = 32'h1234_5678;
		tim2 = 32'h9abc_def0;
		src = 32'h0000_0003;
		pol = 16'h0002;
		filt = 16'h0000;
		ch_en = 16'h0003;
		db_en = 16'h0000;
		db_dur = 4'h1;
		// channel i watches source i
		for (int i = 0; i < NUM_CH; i++) begin
			sel[i*SRC_W +: SRC_W] = SRC_W'(i);
		end
		repeat (10) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		cyc(1);
		state(4'h0, 4'h0, 3'b000);
		log_en = 1'b1;
		cyc(8);
		state(4'h1, 4'h0, 3'b100);
		entry(4'h0, 5'h00, 1'b0, tim1);
		set(1, 1'b0);
		state(4'h2, 4'h0, 3'b100);
		entry(4'h1, 5'h01, 1'b1, tim1);
		log_en = 1'b0;
		cyc(2);
		pulse(0);
		state(4'h2, 4'h0, 3'b100);
		tsel = 1'b1;
		cyc(1);
		log_en = 1'b1;
		cyc(8);
		state(4'h3, 4'h0, 3'b100);
		entry(4'h2, 5'h01, 1'b1, tim2);
		set(9, 1'b1);
		chk(32'(lvl), 32'h0000_0200, "level status");
		wr_rp(4'h3);
		state(4'h3, 4'h3, 3'b000);
		ch_en = 16'h0000;
		pulse(2);
		state(4'h3, 4'h3, 3'b000);
		// two channels fire together: lower number is written first
		ch_en = 16'h0060;
		cyc(1);
		src[6:5] = 2'b11;
		cyc(10);
		state(4'h5, 4'h3, 3'b100);
		entry(4'h3, 5'h05, 1'b0, tim2);
		entry(4'h4, 5'h06, 1'b0, tim2);
		ch_en = 16'h0000;
		filt[3] = 1'b1;
		cyc(1);
		ch_en = 16'h0008;
		pulse(3);
		pulse(3);
		state(4'h6, 4'h3, 3'b100);
		entry(4'h5, 5'h03, 1'b0, tim2);
		wr_rp(4'h6);
		pulse(3);
		state(4'h7, 4'h6, 3'b100);
		// fill to full and watch the low-space flag on every step
		wr_rp(4'h7);
		thr = 4'h3;
		ch_en = 16'h0004;
		for (int k = 1; k <= DEPTH; k++) begin
			pulse(2);
			chk(32'(low), 32'((DEPTH - k) <= 3), "low space");
			chk(32'(full), 32'(k == DEPTH), "full");
		end
		state(4'h7, 4'h7, 3'b111);
		pulse(2);
		state(4'h7, 4'h7, 3'b111);
		wr_rp(4'h7);
		state(4'h7, 4'h7, 3'b111);
		wr_rp(4'h8);
		state(4'h7, 4'h8, 3'b110);
		wr_rp(4'h7);
		state(4'h7, 4'h7, 3'b000);
		pulse(2);
		state(4'h8, 4'h7, 3'b100);
		// debounced channel: a short glitch is dropped, a held level is logged
		ch_en = 16'h0000;
		db_en[10] = 1'b1;
		cyc(1);
		ch_en = 16'h0400;
		pulse(10);
		state(4'h8, 4'h7, 3'b100);
		src[10] = 1'b1;
		cyc(2100);
		state(4'h9, 4'h7, 3'b100);
		entry(4'h8, 5'h0a, 1'b0, tim2);
		soft_rst = 1'b1;
		cyc(1);
		soft_rst = 1'b0;
		cyc(1);
		state(4'h0, 4'h0, 3'b000);
		entry(4'h7, 5'h00, 1'b0, 32'h0000_0000);
		tally_and_finish();
	end

endmodule
